// ===== hw/ored_pkg.sv
// Package with address map, register layout and types for the on-chip RAM block
package ored_pkg;
  // Window bounds for modes 1 and 2 (20-bit space) and modes 3 and 4 (24-bit space)
  localparam logic [23:0] WIN_LO_M12 = 24'h0FEF20;
  localparam logic [23:0] WIN_HI_M12 = 24'h0FFF1F;
  localparam logic [23:0] WIN_LO_M34 = 24'hFFEF20;
  localparam logic [23:0] WIN_HI_M34 = 24'hFFFF1F;
  // Array size in bytes and in 16-bit words
  localparam int RAM_BYTES = 4096;
  localparam int RAM_WORDS = RAM_BYTES / 2;
  localparam int WORD_AW = 11;
  // System control register
  localparam logic [23:0] SYS_CTRL_OFS = 24'h0EE012;
  localparam logic [7:0] SYS_CTRL_RESET = 8'h09;
  localparam int RAM_EN_BIT = 0;
  // Access lasts two states
  localparam logic [1:0] ACC_STATES = 2'h2;
  // Register port widths
  localparam int REG_AW = 24;

  typedef enum logic [2:0] {
    ORED_MODE_1,
    ORED_MODE_2,
    ORED_MODE_3,
    ORED_MODE_4,
    ORED_MODE_SINGLE
  } ored_mode_e;

  // CPU access request over the internal bus
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic word;
  } ored_req_s;

  // Routed external access
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic word;
  } ored_ext_s;
endpackage

// ===== hw/ored_ram.sv
// On-chip static RAM with enable bit, window decode and external routing
//
// Overview of operation
// - When enabled, addresses in the mode's window are served by the internal array.
// - The internal array holds 4 kbytes mapped into the decoded window.
// - In modes 1 to 4 with enable bit 0, window accesses go external.
// - Enable is bit 0 of system control; 1 enables, 0 disables except in single-chip mode.
// - Enable bit returns to 1 on the rising edge of the reset pin.
// - Software standby leaves the enable bit untouched.
// - The array accepts byte and word reads and writes on the 16-bit bus.
// - Byte access takes two states and uses the upper eight data lines.
// - Word access at an even address takes two states, all 16 lines.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module ored_ram #(
  parameter int WORDS = ored_pkg::RAM_WORDS
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [2:0] mode,
  input wire logic sw_standby,
  // Register port
  input wire logic [23:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // CPU access port; a request is a one-cycle strobe
  input wire ored_pkg::ored_req_s cpu_req,
  output logic cpu_busy,
  output logic cpu_done,
  output logic [15:0] cpu_rdata,
  output logic cpu_hit,
  // External routing
  output ored_pkg::ored_ext_s ext_req,
  output logic ram_enable_bit
);

  logic [15:0] mem [WORDS];
  logic [7:0] system_control_register;
  logic resetn_s1;
  logic resetn_s2;
  logic resetn_d;
  logic in_win;
  logic [11:0] byte_off;
  logic hit;
  logic [ored_pkg::WORD_AW-1:0] widx;
  logic [1:0] st_cnt;
  logic acc_wr;
  logic acc_word;
  logic acc_lo;
  logic [ored_pkg::WORD_AW-1:0] acc_idx;
  logic [15:0] acc_wdata;

  // Window decode for the current mode; single-chip mode has no external space
  function automatic logic win(input logic [2:0] m, input logic [23:0] a);
    if (m == ored_pkg::ORED_MODE_1 || m == ored_pkg::ORED_MODE_2) begin
      win = (a[23:20] == 4'h0) && (a >= ored_pkg::WIN_LO_M12) && (a <= ored_pkg::WIN_HI_M12);
    end else begin
      win = (a >= ored_pkg::WIN_LO_M34) && (a <= ored_pkg::WIN_HI_M34);
    end
  endfunction

  // Byte index into the array, relative to the window base
  function automatic logic [11:0] boff(input logic [2:0] m, input logic [23:0] a);
    logic [23:0] d;
    d = 24'h000000;
    if (m == ored_pkg::ORED_MODE_1 || m == ored_pkg::ORED_MODE_2) begin
      d = a - ored_pkg::WIN_LO_M12;
    end else begin
      d = a - ored_pkg::WIN_LO_M34;
    end
    boff = d[11:0];
  endfunction

  // Reset pin synchroniser; the rising edge is seen on the second stage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      resetn_s1 <= 1'b0;
      resetn_s2 <= 1'b0;
      resetn_d <= 1'b0;
    end else begin
      resetn_s1 <= 1'b1;
      resetn_s2 <= resetn_s1;
      resetn_d <= resetn_s2;
    end
  end

  // System control register; standby input deliberately has no effect here
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      system_control_register <= ored_pkg::SYS_CTRL_RESET;
    end else if (resetn_s2 && !resetn_d) begin
      system_control_register[ored_pkg::RAM_EN_BIT] <= 1'b1;
    end else if (reg_wr && reg_addr == ored_pkg::SYS_CTRL_OFS) begin
      system_control_register <= reg_wdata;
    end
  end

  assign ram_enable_bit = system_control_register[ored_pkg::RAM_EN_BIT];

  // Register read, one cycle later; unmapped reads return zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_addr == ored_pkg::SYS_CTRL_OFS) begin
      reg_rdata <= system_control_register;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Internal hit only when enabled; in single-chip mode window accesses always stay internal
  assign in_win = win(mode, cpu_req.addr);
  assign hit = in_win && (ram_enable_bit || mode == ored_pkg::ORED_MODE_SINGLE);
  assign byte_off = boff(mode, cpu_req.addr);
  assign widx = byte_off[11:1];
  assign cpu_busy = (st_cnt != 2'h0);

  // Route non-hits outside; registered so the external strobe is one cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_req <= '0;
      cpu_hit <= 1'b0;
    end else begin
      ext_req <= '0;
      cpu_hit <= 1'b0;
      if ((cpu_req.rd || cpu_req.wr) && !cpu_busy) begin
        cpu_hit <= hit;
        if (!hit) begin
          ext_req.addr <= cpu_req.addr;
          ext_req.wdata <= cpu_req.wdata;
          ext_req.wr <= cpu_req.wr;
          ext_req.rd <= cpu_req.rd;
          ext_req.word <= cpu_req.word;
        end
      end
    end
  end

  // Two-state access sequencer for internal hits
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_cnt <= 2'h0;
      acc_wr <= 1'b0;
      acc_word <= 1'b0;
      acc_lo <= 1'b0;
      acc_idx <= '0;
      acc_wdata <= 16'h0000;
      cpu_done <= 1'b0;
    end else begin
      cpu_done <= 1'b0;
      if (!cpu_busy && (cpu_req.rd || cpu_req.wr) && hit) begin
        st_cnt <= ored_pkg::ACC_STATES - 2'h1;
        acc_wr <= cpu_req.wr;
        acc_word <= cpu_req.word;
        acc_lo <= cpu_req.addr[0];
        acc_idx <= widx;
        acc_wdata <= cpu_req.wdata;
      end else if (cpu_busy) begin
        st_cnt <= st_cnt - 2'h1;
        cpu_done <= (st_cnt == 2'h1);
      end
    end
  end

  // Array write in the second state; only hits reach here
  always_ff @(posedge clk_sys) begin
    if (cpu_busy && st_cnt == 2'h1 && acc_wr) begin
      if (acc_word) begin
        mem[acc_idx] <= acc_wdata;
      end else if (acc_lo) begin
        mem[acc_idx][7:0] <= acc_wdata[15:8];
      end else begin
        mem[acc_idx][15:8] <= acc_wdata[15:8];
      end
    end
  end

  // Read data; byte reads land on the upper lines
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cpu_rdata <= 16'h0000;
    end else if (cpu_busy && st_cnt == 2'h1 && !acc_wr) begin
      if (acc_word) begin
        cpu_rdata <= mem[acc_idx];
      end else if (acc_lo) begin
        cpu_rdata <= {mem[acc_idx][7:0], 8'h00};
      end else begin
        cpu_rdata <= {mem[acc_idx][15:8], 8'h00};
      end
    end
  end

  // Hardware standby preparation is software's duty
  // the block assumes the enable bit was cleared beforehand

  // Checks below watch only what this block drives
  // Decode, routing and access timing checks
  hit_two_states_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((cpu_req.rd || cpu_req.wr) && !cpu_busy && hit) |-> ##2 cpu_done)
    else $error("internal access did not finish in two states");

  disabled_goes_ext_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((cpu_req.rd || cpu_req.wr) && !cpu_busy && in_win && !ram_enable_bit
     && mode != ored_pkg::ORED_MODE_SINGLE) |=> (ext_req.rd || ext_req.wr))
    else $error("disabled window access not routed outside");

  enabled_stays_int_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((cpu_req.rd || cpu_req.wr) && !cpu_busy && in_win && ram_enable_bit)
    |=> (cpu_hit && !ext_req.rd && !ext_req.wr))
    else $error("enabled window access leaked outside");

  // Single-chip mode has no external space, so the window stays inside even when disabled
  single_chip_int_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((cpu_req.rd || cpu_req.wr) && !cpu_busy && in_win
     && mode == ored_pkg::ORED_MODE_SINGLE) |=> cpu_hit)
    else $error("single-chip window access left the array");

  ext_copy_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((cpu_req.rd || cpu_req.wr) && !cpu_busy && !hit)
    |=> (ext_req.addr == $past(cpu_req.addr) && ext_req.wr == $past(cpu_req.wr)))
    else $error("routed access does not carry the request");

  ext_no_busy_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((cpu_req.rd || cpu_req.wr) && !cpu_busy && !hit) |=> !cpu_busy)
    else $error("external access started the array");

  busy_one_state_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cpu_busy |=> !cpu_busy)
    else $error("internal access held the bus past two states");

  done_one_cycle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cpu_done |=> !cpu_done)
    else $error("done pulse longer than one cycle");

  // Array data path; the access registers hold until the next take, so no history is needed
  word_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cpu_busy && acc_wr && acc_word) |=> (mem[acc_idx] == acc_wdata))
    else $error("word write did not land");

  byte_write_hi_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cpu_busy && acc_wr && !acc_word && !acc_lo) |=> (mem[acc_idx][15:8] == acc_wdata[15:8]))
    else $error("even byte write did not land");

  byte_write_lo_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cpu_busy && acc_wr && !acc_word && acc_lo) |=> (mem[acc_idx][7:0] == acc_wdata[15:8]))
    else $error("odd byte write did not land");

  word_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cpu_busy && !acc_wr && acc_word) |=> (cpu_rdata == mem[acc_idx]))
    else $error("word read data wrong");

  byte_read_hi_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cpu_busy && !acc_wr && !acc_word && !acc_lo) |=> (cpu_rdata[15:8] == mem[acc_idx][15:8]))
    else $error("even byte read data wrong");

  byte_read_lo_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cpu_busy && !acc_wr && !acc_word && acc_lo) |=> (cpu_rdata[15:8] == mem[acc_idx][7:0]))
    else $error("odd byte read data wrong");

  byte_upper_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cpu_done && !acc_wr && !acc_word) |-> (cpu_rdata[7:0] == 8'h00))
    else $error("byte read not on upper lines");

  // Register checks; the set at reset release wins over a write in the same cycle
  enable_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_wr && reg_addr == ored_pkg::SYS_CTRL_OFS && !(resetn_s2 && !resetn_d))
    |=> (ram_enable_bit == $past(reg_wdata[0])))
    else $error("enable bit did not follow write");

  standby_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sw_standby && !reg_wr && resetn_d) |=> $stable(ram_enable_bit))
    else $error("enable bit changed in software standby");

  enable_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!(reg_wr && reg_addr == ored_pkg::SYS_CTRL_OFS) && resetn_d)
    |=> $stable(ram_enable_bit))
    else $error("enable bit changed without a write");

  reset_edge_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (resetn_s2 && !resetn_d) |=> ram_enable_bit)
    else $error("enable bit not set at reset release");

  reg_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_rd && reg_addr == ored_pkg::SYS_CTRL_OFS)
    |=> (reg_rdata == $past(system_control_register)))
    else $error("register read mismatch");

  idle_read_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(reg_rd && reg_addr == ored_pkg::SYS_CTRL_OFS) |=> (reg_rdata == 8'h00))
    else $error("read data not zero outside a mapped read");

  // Coverage of the main scenarios
  word_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    cpu_done && acc_word && acc_wr);
  byte_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    cpu_done && !acc_word && !acc_wr);
  ext_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    ext_req.wr && win(mode, ext_req.addr));
  single_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    cpu_hit && mode == ored_pkg::ORED_MODE_SINGLE && !ram_enable_bit);
  rst_set_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    resetn_s2 && !resetn_d);
endmodule

// ===== test/ored_cpu_model.sv
// CPU-side model that issues single accesses on the internal 16-bit bus
`timescale 1ns/1ns
module ored_cpu_model (
  input wire logic clk_sys,
  output ored_pkg::ored_req_s cpu_req,
  input wire logic cpu_busy,
  input wire logic cpu_done,
  input wire logic [15:0] cpu_rdata,
  input wire logic cpu_hit,
  input wire ored_pkg::ored_ext_s ext_req
);
  initial cpu_req = '0;
  // One access; callers wait for completion, so busy is always low at the start
  task automatic access(input logic [23:0] a, input logic [15:0] d, input logic wr,
    input logic word, output logic [15:0] q, output logic hit, output logic ext,
    output logic [23:0] ea, output int states, output logic bsy);
    @(posedge clk_sys);
    cpu_req <= '{addr: a, wdata: d, wr: wr, rd: !wr, word: word};
    @(posedge clk_sys);
    cpu_req.wr <= 1'b0;
    cpu_req.rd <= 1'b0;
    #1;
    hit = cpu_hit;
    // Busy stands only in the state after the take of an internal access
    bsy = cpu_busy;
    ext = ext_req.wr | ext_req.rd;
    ea = ext_req.addr;
    states = 1;
    q = 16'h0;
    // Bounded wait so a stuck access cannot hang the model
    while (hit && cpu_done !== 1'b1 && states < 8) begin
      @(posedge clk_sys);
      #1;
      states++;
    end
    if (hit) q = cpu_rdata;
  endtask
endmodule

// ===== test/tb_onchip_ram_enable_decode.sv
// Self-checking testbench for the on-chip RAM block
`timescale 1ns/1ns
module tb_onchip_ram_enable_decode;
  logic clk_sys, resetn, sw_standby, reg_wr, reg_rd, cpu_busy, cpu_done, cpu_hit;
  logic ram_enable_bit, h, e, b;
  logic [2:0] mode;
  logic [23:0] reg_addr, ea, base;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] cpu_rdata, q;
  ored_pkg::ored_req_s cpu_req;
  ored_pkg::ored_ext_s ext_req;
  int st, err_total, n_tests;
  ored_ram #(.WORDS(ored_pkg::RAM_WORDS)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
    .mode(mode), .sw_standby(sw_standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_req(cpu_req),
    .cpu_busy(cpu_busy), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit),
    .ext_req(ext_req), .ram_enable_bit(ram_enable_bit));
  ored_cpu_model u_cpu (.clk_sys(clk_sys), .cpu_req(cpu_req), .cpu_busy(cpu_busy),
    .cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit), .ext_req(ext_req));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Register access; read data is sampled in the cycle after the strobe
  task automatic reg_io(input logic [23:0] a, input logic [7:0] d, input logic wr);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  // Internal accesses must end in two states; external ones carry the address out
  task automatic mem(input logic [23:0] a, input logic [15:0] d, input logic wr,
    input logic word, input logic [15:0] eq, input logic eh);
    u_cpu.access(a, d, wr, word, q, h, e, ea, st, b);
    chk(24'(h), 24'(eh), "internal");
    chk(24'(e), 24'(!eh), "external");
    chk(24'(b), 24'(eh), "busy");
    if (eh) chk(24'(st), 24'(ored_pkg::ACC_STATES), "states");
    if (eh && !wr) chk(24'(q), 24'(eq), "read data");
    if (!eh) chk(ea, a, "ext addr");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Whole sequence needs well under 400 cycles
  initial begin
    repeat (2000) @(posedge clk_sys);
    err_total++;
    give_verdict();
  end
  initial begin
    {resetn, sw_standby, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    mode = 3'h2;
    err_total = 0;
    n_tests = 0;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    reg_io(ored_pkg::SYS_CTRL_OFS, 8'h00, 1'b0);
    chk(24'(reg_rdata), 24'(ored_pkg::SYS_CTRL_RESET), "reset value");
    reg_io(24'h0EE013, 8'h00, 1'b0);
    chk(24'(reg_rdata), 24'h000000, "unmapped");
    mem(24'hFFEF20, 16'hA55A, 1'b1, 1'b1, 16'h0, 1'b1);
    mem(24'hFFFF1F, 16'h3C00, 1'b1, 1'b0, 16'h0, 1'b1);
    mem(24'hFFFF1E, 16'hC300, 1'b1, 1'b0, 16'h0, 1'b1);
    mem(24'hFFFF1E, 16'h0, 1'b0, 1'b1, 16'hC33C, 1'b1);
    mem(24'hFFFF1F, 16'h0, 1'b0, 1'b0, 16'h3C00, 1'b1);
    mem(24'hFFEF1F, 16'h0, 1'b0, 1'b0, 16'h0, 1'b0);
    mem(24'hFFFF20, 16'h0, 1'b0, 1'b0, 16'h0, 1'b0);
    // Every expanded mode reaches the same word at its window base
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      mode <= 3'(m);
      base = (m < 2) ? ored_pkg::WIN_LO_M12 : ored_pkg::WIN_LO_M34;
      mem(base, 16'h0, 1'b0, 1'b1, 16'hA55A, 1'b1);
    end
    @(posedge clk_sys);
    mode <= 3'h2;
    reg_io(ored_pkg::SYS_CTRL_OFS, 8'h08, 1'b1);
    chk(24'(ram_enable_bit), 24'h000000, "enable clear");
    @(posedge clk_sys);
    sw_standby <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sw_standby <= 1'b0;
    // Look half a cycle later so the register has settled
    @(negedge clk_sys);
    chk(24'(ram_enable_bit), 24'h000000, "standby");
    mem(24'hFFEF20, 16'h1111, 1'b1, 1'b1, 16'h0, 1'b0);
    mem(24'hFFEF20, 16'h0, 1'b0, 1'b1, 16'h0, 1'b0);
    // Single-chip mode has no external space, so the array answers with the bit clear
    @(posedge clk_sys);
    mode <= 3'(ored_pkg::ORED_MODE_SINGLE);
    mem(24'hFFEF20, 16'h0, 1'b0, 1'b1, 16'hA55A, 1'b1);
    @(posedge clk_sys);
    mode <= 3'h2;
    reg_io(ored_pkg::SYS_CTRL_OFS, 8'h09, 1'b1);
    mem(24'hFFEF20, 16'h0, 1'b0, 1'b1, 16'hA55A, 1'b1);
    // Cleared ahead of the reset pin drop, as ahead of hardware standby
    reg_io(ored_pkg::SYS_CTRL_OFS, 8'h08, 1'b1);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(24'(ram_enable_bit), 24'h000001, "reset set");
    mem(24'hFFEF20, 16'h0, 1'b0, 1'b1, 16'hA55A, 1'b1);
    give_verdict();
  end
endmodule
